// File: core/fault_error_record_regs.sv
// Purpose: Fault manager error record register bank with interrupts.
// Assumes: Plain register port, read data one cycle after the strobe;
//          error event inputs come from logic on clk_i.
// Notes:   Notes on behaviour follow.
// Notes on behaviour
// - Records at 64-byte stride: feature, control, status.
// - Feature reads fixed 0xA2; interrupt feature controllable.
// - Recovery interrupt and logging features controllable.
// - Control bit 0 enables logging; resets 0x1.
// - Control bit 3 raises fault-handling interrupt.
// - Control bit 2 raises recovery interrupt on uncorrected.
// - Bit 1 clear: correctable reported as uncorrectable.
// - One uncorrected error may raise both interrupts.
// - Only Secure accesses read or modify registers.
// - Status register 64-bit, write-one-to-clear, resets 0x30_0000.
// - Group summary at 0xE00, read-only, reset zero.
// - Key, ping control, ping-now registers, reset zero.
// - Safety enable and inject registers write-only.
// - Unit status at 0xF00 reads 0x1 after reset.
// - Record identification at 0xFC8 reads 0x2C.
`include "fault_manager_defs.svh"

module fault_error_record_regs (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    // Register port
    input  wire logic [11:0]              addr_i,
    input  wire logic [31:0]              wdata_i,
    input  wire logic                     wr_i,
    input  wire logic                     rd_i,
    input  wire logic                     secure_i,
    output logic      [31:0]              rdata_o,
    // Error events, one bit per record
    input  wire logic [`FM_NUM_REC-1:0]   err_valid_i,
    input  wire logic [`FM_NUM_REC-1:0]   err_corrected_i,
    // Interrupts
    output logic                          fault_handling_irq_o,
    output logic                          error_recovery_irq_o,
    output logic                          irq_o,
    // Settings toward the safety logic
    output logic      [31:0]              key_o,
    output logic      [31:0]              ping_ctl_o,
    output logic      [31:0]              ping_now_o,
    output logic      [63:0]              ping_mask_o,
    output logic      [31:0]              sm_enable_o,
    output logic      [31:0]              sm_inject_o
);

    localparam int NR = `FM_NUM_REC;

    fault_manager_pkg::state_t st;
    fault_manager_pkg::state_t next_st;

    // Address falls inside the record area
    function automatic logic rec_hit(input logic [11:0] a);
        rec_hit = (a[11:`FM_REC_SHIFT+`FM_REC_BITS] == '0);
    endfunction

    function automatic logic [`FM_REC_BITS-1:0] rec_idx(input logic [11:0] a);
        rec_idx = a[`FM_REC_SHIFT+`FM_REC_BITS-1:`FM_REC_SHIFT];
    endfunction

    // Correctable errors count as uncorrected unless kept apart
    function automatic logic unc_reported(input logic corr,
                                          input logic ce_en);
        unc_reported = !corr || !ce_en;
    endfunction

    function automatic logic [31:0] sts_word(input logic [3:0] s);
        logic [31:0] w;
        w = `FM_STS_FIXED;
        w[`FM_STW_V]  = s[`FM_ST_V];
        w[`FM_STW_UNC] = s[`FM_ST_UNC];
        w[`FM_STW_OF] = s[`FM_ST_OF];
        w[`FM_STW_CE] = s[`FM_ST_CE];
        sts_word = w;
    endfunction

    logic                    acc_wr;
    logic                    acc_rd;
    logic                    sts_wr;
    logic [5:0]              sub;
    logic [NR-1:0]           v_bits;

    // Non-Secure strobes are dropped before any decode
    assign acc_wr = wr_i && secure_i;
    assign acc_rd = rd_i && secure_i;
    assign sub    = addr_i[5:0];
    assign sts_wr = acc_wr && rec_hit(addr_i) && sub == `FM_SUB_STS_LO;

    always_comb begin
        logic [NR-1:0][3:0] set_b;
        logic [NR-1:0][3:0] clr_b;
        logic [2*NR-1:0]    ev;
        logic [2*NR-1:0]    irq_clr;
        logic               unc;
        logic [`FM_REC_BITS-1:0] ix;
        set_b   = '0;
        clr_b   = '0;
        ev      = '0;
        irq_clr = '0;
        unc     = 1'b0;
        ix      = rec_idx(addr_i);
        next_st = st;
        next_st.rdata = 32'h0000_0000;
        v_bits  = '0;

        // Error capture per record
        for (int r = 0; r < NR; r++) begin
            v_bits[r] = st.sts[r][`FM_ST_V];
            unc = unc_reported(err_corrected_i[r], st.ctl[r][`FM_CTL_CE_EN]);
            if (err_valid_i[r] && st.ctl[r][`FM_CTL_LOG]) begin
                set_b[r][`FM_ST_V]   = 1'b1;
                set_b[r][`FM_ST_OF]  = st.sts[r][`FM_ST_V];
                set_b[r][`FM_ST_UNC] = unc;
                set_b[r][`FM_ST_CE]  = !unc;
                // Both interrupts may fire from one error
                ev[r]      = st.ctl[r][`FM_CTL_FLT];
                ev[NR + r] = st.ctl[r][`FM_CTL_RCV] && unc;
            end
        end

        // Register writes
        if (acc_wr) begin
            if (rec_hit(addr_i)) begin
                case (sub)
                    `FM_SUB_CTL_LO: begin
                        next_st.ctl[ix] = wdata_i[3:0];
                    end
                    `FM_SUB_STS_LO: begin
                        clr_b[ix][`FM_ST_V]  = wdata_i[`FM_STW_V];
                        clr_b[ix][`FM_ST_UNC] = wdata_i[`FM_STW_UNC];
                        clr_b[ix][`FM_ST_OF] = wdata_i[`FM_STW_OF];
                        clr_b[ix][`FM_ST_CE] = wdata_i[`FM_STW_CE];
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (addr_i)
                    `FM_KEY:          next_st.key       = wdata_i;
                    `FM_PING_CTL:     next_st.ping_ctl  = wdata_i;
                    `FM_PING_NOW:     next_st.ping_now  = wdata_i;
                    `FM_SM_ENABLE:    next_st.sm_enable = wdata_i;
                    `FM_SM_INJECT:    next_st.sm_inject = wdata_i;
                    `FM_PING_MASK_LO: next_st.ping_mask[31:0] = wdata_i;
                    `FM_PING_MASK_HI: next_st.ping_mask[63:32] = wdata_i;
                    `FM_IRQ_STATUS:   irq_clr = wdata_i[2*NR-1:0];
                    `FM_IRQ_MASK:     next_st.irq_mask = wdata_i[2*NR-1:0];
                    default: begin
                    end
                endcase
            end
        end

        // A new error wins over a clear in the same cycle
        for (int r = 0; r < NR; r++) begin
            next_st.sts[r] = (st.sts[r] & ~clr_b[r]) | set_b[r];
        end
        next_st.irq_pend = (st.irq_pend & ~irq_clr) | ev;

        // Status write takes a few cycles to settle
        if (sts_wr) begin
            next_st.settle = `FM_SETTLE_CYC;
        end else if (st.settle != 2'h0) begin
            next_st.settle = st.settle - 2'h1;
        end

        // Register reads, reserved and write-only read zero
        if (acc_rd) begin
            if (rec_hit(addr_i)) begin
                case (sub)
                    `FM_SUB_FEAT_LO: next_st.rdata = `FM_FEAT_VALUE;
                    `FM_SUB_CTL_LO:  next_st.rdata = {28'h0, st.ctl[ix]};
                    `FM_SUB_STS_LO:  next_st.rdata = sts_word(st.sts[ix]);
                    default:         next_st.rdata = 32'h0000_0000;
                endcase
            end else begin
                case (addr_i)
                    `FM_GSR_LO:       next_st.rdata = 32'(v_bits);
                    `FM_KEY:          next_st.rdata = st.key;
                    `FM_PING_CTL:     next_st.rdata = st.ping_ctl;
                    `FM_PING_NOW:     next_st.rdata = st.ping_now;
                    `FM_PING_MASK_LO: next_st.rdata = st.ping_mask[31:0];
                    `FM_PING_MASK_HI: next_st.rdata = st.ping_mask[63:32];
                    `FM_UNIT_STATUS:  next_st.rdata =
                                          {31'h0, st.settle == 2'h0};
                    `FM_REC_COUNT:    next_st.rdata = `FM_REC_COUNT_VAL;
                    `FM_IRQ_STATUS:   next_st.rdata = 32'(st.irq_pend);
                    `FM_IRQ_MASK:     next_st.rdata = 32'(st.irq_mask);
                    default:          next_st.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Outputs follow the next pending state so they stay registered
        next_st.fault_out = |(next_st.irq_pend[NR-1:0]
                              & next_st.irq_mask[NR-1:0]);
        next_st.recov_out = |(next_st.irq_pend[2*NR-1:NR]
                              & next_st.irq_mask[2*NR-1:NR]);
        next_st.irq_out   = next_st.fault_out || next_st.recov_out;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st     <= '0;
            st.ctl <= {NR{`FM_CTL_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o              = st.rdata;
    assign fault_handling_irq_o = st.fault_out;
    assign error_recovery_irq_o = st.recov_out;
    assign irq_o                = st.irq_out;
    assign key_o                = st.key;
    assign ping_ctl_o           = st.ping_ctl;
    assign ping_now_o           = st.ping_now;
    assign ping_mask_o          = st.ping_mask;
    assign sm_enable_o          = st.sm_enable;
    assign sm_inject_o          = st.sm_inject;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_rd(logic [11:0] a);
        rd_i && secure_i && addr_i == a;
    endsequence

    sequence s_err0;
        err_valid_i[0] && st.ctl[0][`FM_CTL_LOG];
    endsequence

    sequence s_err1;
        err_valid_i[1] && st.ctl[1][`FM_CTL_LOG];
    endsequence

    sequence s_wr(logic [11:0] a);
        wr_i && secure_i && addr_i == a;
    endsequence

    feat_read_a: assert property (
        s_rd(12'h000) |=> rdata_o == 32'h0000_00A2)
        else $error("feature register value wrong");

    feat_resv_a: assert property (
        s_rd(12'h004) |=> rdata_o == 32'h0000_0000)
        else $error("reserved feature word not zero");

    log_gate_a: assert property (
        err_valid_i[0] && !st.ctl[0][`FM_CTL_LOG] && !st.sts[0][`FM_ST_V]
        |=> !st.sts[0][`FM_ST_V])
        else $error("error logged while logging disabled");

    fault_irq_a: assert property (
        s_err0 and (st.ctl[0][`FM_CTL_FLT] && st.irq_mask[0])
        |=> fault_handling_irq_o && irq_o)
        else $error("fault handling interrupt missing");

    recov_irq_a: assert property (
        s_err0 and (st.ctl[0][`FM_CTL_RCV] && !err_corrected_i[0])
        |=> st.irq_pend[NR])
        else $error("recovery interrupt missing");

    ce_as_unc_a: assert property (
        s_err0 and (err_corrected_i[0] && !st.ctl[0][`FM_CTL_CE_EN])
        |=> st.sts[0][`FM_ST_UNC] && !st.sts[0][`FM_ST_CE])
        else $error("correctable not reported as uncorrected");

    both_irq_a: assert property (
        s_err0 and (st.ctl[0][`FM_CTL_FLT] && st.ctl[0][`FM_CTL_RCV]
        && !err_corrected_i[0]) |=> st.irq_pend[0] && st.irq_pend[NR])
        else $error("both interrupts not raised together");

    nonsec_rd_a: assert property (
        rd_i && !secure_i |=> rdata_o == 32'h0000_0000)
        else $error("non-secure read returned data");

    nonsec_wr_a: assert property (
        wr_i && !secure_i && addr_i == 12'hEA0 |=> $stable(key_o))
        else $error("non-secure write changed a register");

    sts_fixed_a: assert property (
        s_rd(12'h010) && st.sts[0] == 4'h0
        |=> rdata_o == 32'h0030_0000)
        else $error("clean status value wrong");

    gsr_read_a: assert property (
        s_rd(12'hE00) |=> rdata_o == 32'($past(v_bits)))
        else $error("group summary mismatch");

    settle_busy_a: assert property (
        sts_wr |=> (st.settle != 2'h0) [*2])
        else $error("unit not busy after status write");

    settle_idle_a: assert property (
        sts_wr ##1 (!sts_wr) [*2] |=> st.settle == 2'h0)
        else $error("unit not idle after settle time");

    rec_count_a: assert property (
        s_rd(12'hFC8) |=> rdata_o == 32'h0000_002C)
        else $error("record count value wrong");

    ctl_write_a: assert property (
        s_wr(12'h008)
        |=> {28'h0, st.ctl[0]} == ($past(wdata_i) & 32'h0000_000F))
        else $error("control write not kept");

    ctl_read_a: assert property (
        s_rd(12'h008) |=> rdata_o[31:4] == 28'h0)
        else $error("reserved control bits not zero");

    key_write_a: assert property (
        s_wr(12'hEA0) |=> key_o == $past(wdata_i))
        else $error("key write not kept");

    mask_high_a: assert property (
        s_wr(12'hEC4) |=> ping_mask_o[63:32] == $past(wdata_i))
        else $error("ping mask high word not kept");

    sts_clear_a: assert property (
        s_wr(12'h010) and (wdata_i[`FM_STW_V] && !err_valid_i[0])
        |=> !st.sts[0][`FM_ST_V])
        else $error("status valid bit not cleared");

    of_set_a: assert property (
        s_err0 and st.sts[0][`FM_ST_V] |=> st.sts[0][`FM_ST_OF])
        else $error("overflow not set on second error");

    ce_split_a: assert property (
        s_err1 and (err_corrected_i[1] && st.ctl[1][`FM_CTL_CE_EN])
        |=> st.sts[1][`FM_ST_CE])
        else $error("correctable error not kept apart");

    rcv_corr_a: assert property (
        s_err1 and (err_corrected_i[1] && st.ctl[1][`FM_CTL_CE_EN]
        && !st.irq_pend[NR+1]) |=> !st.irq_pend[NR+1])
        else $error("recovery interrupt on a corrected error");

    log_irq_a: assert property (
        err_valid_i[0] && !st.ctl[0][`FM_CTL_LOG] && !st.irq_pend[0]
        |=> !st.irq_pend[0])
        else $error("interrupt raised while logging disabled");

    busy_read_a: assert property (
        s_rd(12'hF00) and (st.settle != 2'h0)
        |=> rdata_o == 32'h0000_0000)
        else $error("unit status idle while settling");

    idle_read_a: assert property (
        s_rd(12'hF00) and (st.settle == 2'h0)
        |=> rdata_o == 32'h0000_0001)
        else $error("unit status busy while idle");

    resv_read_a: assert property (
        s_rd(12'hFFC) |=> rdata_o == 32'h0000_0000)
        else $error("unmapped address not zero");

    wo_read_a: assert property (
        s_rd(12'hEB0) |=> rdata_o == 32'h0000_0000)
        else $error("write-only register readable");

    gsr_high_a: assert property (
        s_rd(12'hE04) |=> rdata_o == 32'h0000_0000)
        else $error("group summary high word not zero");

endmodule

// File: core/fault_manager_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          fault manager register bank.
// Assumes: 12-bit byte address, 32-bit data words.
// Notes:   64-bit registers take two words, low word first.
`ifndef FAULT_MANAGER_DEFS_SVH
`define FAULT_MANAGER_DEFS_SVH

// Records
`define FM_NUM_REC        4
`define FM_REC_BITS       2
`define FM_REC_SHIFT      6
`define FM_SUB_FEAT_LO    6'h00
`define FM_SUB_FEAT_HI    6'h04
`define FM_SUB_CTL_LO     6'h08
`define FM_SUB_CTL_HI     6'h0C
`define FM_SUB_STS_LO     6'h10
`define FM_SUB_STS_HI     6'h14

// Unit registers
`define FM_GSR_LO         12'hE00
`define FM_GSR_HI         12'hE04
`define FM_KEY            12'hEA0
`define FM_PING_CTL       12'hEA4
`define FM_PING_NOW       12'hEA8
`define FM_SM_ENABLE      12'hEB0
`define FM_SM_INJECT      12'hEB4
`define FM_PING_MASK_LO   12'hEC0
`define FM_PING_MASK_HI   12'hEC4
`define FM_UNIT_STATUS    12'hF00
`define FM_REC_COUNT      12'hFC8
`define FM_IRQ_STATUS     12'hF10
`define FM_IRQ_MASK       12'hF14

// Control fields
`define FM_CTL_LOG        0
`define FM_CTL_CE_EN      1
`define FM_CTL_RCV        2
`define FM_CTL_FLT        3
`define FM_CTL_RESET      4'h1

// Stored status bits and their word positions
`define FM_ST_V           3
`define FM_ST_UNC         2
`define FM_ST_OF          1
`define FM_ST_CE          0
`define FM_STW_V          30
`define FM_STW_UNC        29
`define FM_STW_OF         27
`define FM_STW_CE         24
`define FM_STS_FIXED      32'h0030_0000

// Fixed values
`define FM_FEAT_VALUE     32'h0000_00A2
`define FM_REC_COUNT_VAL  32'h0000_002C
`define FM_SETTLE_CYC     2'h2

`endif

// File: core/fault_manager_pkg.sv
// Purpose: Types of the fault manager register bank.
// Assumes: fault_manager_defs.svh on the include path.
// Notes:   The whole bank state is one packed struct.
`include "fault_manager_defs.svh"

package fault_manager_pkg;

    typedef struct packed {
        logic [`FM_NUM_REC-1:0][3:0]   ctl;
        logic [`FM_NUM_REC-1:0][3:0]   sts;
        logic [31:0]                   key;
        logic [31:0]                   ping_ctl;
        logic [31:0]                   ping_now;
        logic [31:0]                   sm_enable;
        logic [31:0]                   sm_inject;
        logic [63:0]                   ping_mask;
        logic [2*`FM_NUM_REC-1:0]      irq_pend;
        logic [2*`FM_NUM_REC-1:0]      irq_mask;
        logic [1:0]                    settle;
        logic [31:0]                   rdata;
        logic                          fault_out;
        logic                          recov_out;
        logic                          irq_out;
    } state_t;

endpackage

// File: bench/fault_error_record_regs_tb.sv
// Purpose: Self-checking bench for the fault manager register bank.
// Assumes: Plain register port, read data in the cycle after the strobe.
// Notes:   Reset values and write-readback run from tables; then
//          error events, interrupts, settle polling and a second reset.
`include "fault_manager_defs.svh"

module fault_error_record_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;

    logic        clk_i;
    logic        rstn_i;
    logic [11:0] addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic        secure_i;
    logic [31:0] rdata_o;
    logic [3:0]  err_valid_i;
    logic [3:0]  err_corrected_i;
    logic        fault_handling_irq_o;
    logic        error_recovery_irq_o;
    logic        irq_o;
    logic [31:0] key_o;
    logic [31:0] ping_ctl_o;
    logic [31:0] ping_now_o;
    logic [63:0] ping_mask_o;
    logic [31:0] sm_enable_o;
    logic [31:0] sm_inject_o;
    logic [31:0] rv;
    int          n_fail;
    int          check_count;

    // Reset rows: address and expected read (d unused)
    row_t rst_rows[20] = '{
        '{12'h000, 32'h0, 32'h0000_00A2}, '{12'h004, 32'h0, 32'h0},
        '{12'h008, 32'h0, 32'h0000_0001}, '{12'h00C, 32'h0, 32'h0},
        '{12'h010, 32'h0, 32'h0030_0000}, '{12'h014, 32'h0, 32'h0},
        '{12'h0C0, 32'h0, 32'h0000_00A2}, '{12'h0C8, 32'h0, 32'h1},
        '{12'h0D0, 32'h0, 32'h0030_0000}, '{12'hE00, 32'h0, 32'h0},
        '{12'hE04, 32'h0, 32'h0}, '{12'hEA0, 32'h0, 32'h0},
        '{12'hEA4, 32'h0, 32'h0}, '{12'hEA8, 32'h0, 32'h0},
        '{12'hEB0, 32'h0, 32'h0}, '{12'hEC0, 32'h0, 32'h0},
        '{12'hF00, 32'h0, 32'h1}, '{12'hFC8, 32'h0, 32'h0000_002C},
        '{12'h020, 32'h0, 32'h0}, '{12'hFFC, 32'h0, 32'h0}};
    // Write rows: address, written word, expected readback
    row_t wr_rows[13] = '{
        '{12'hEA0, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
        '{12'hEA4, 32'h1234_5678, 32'h1234_5678},
        '{12'hEA8, 32'h0000_0001, 32'h0000_0001},
        '{12'hEC0, 32'hDEAD_BEEF, 32'hDEAD_BEEF},
        '{12'hEC4, 32'hCAFE_F00D, 32'hCAFE_F00D},
        '{12'hEB0, 32'h0000_00FF, 32'h0},
        '{12'hEB4, 32'h0000_0003, 32'h0},
        '{12'h048, 32'hFFFF_FFFF, 32'h0000_000F},
        '{12'h04C, 32'hFFFF_FFFF, 32'h0},
        '{12'h000, 32'hFFFF_FFFF, 32'h0000_00A2},
        '{12'hE00, 32'hFFFF_FFFF, 32'h0},
        '{12'hF00, 32'h0, 32'h1},
        '{12'hFC8, 32'h0, 32'h0000_002C}};

    fault_error_record_regs i_fault_error_record_regs (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .secure_i(secure_i), .rdata_o(rdata_o),
        .err_valid_i(err_valid_i), .err_corrected_i(err_corrected_i),
        .fault_handling_irq_o(fault_handling_irq_o),
        .error_recovery_irq_o(error_recovery_irq_o), .irq_o(irq_o),
        .key_o(key_o), .ping_ctl_o(ping_ctl_o), .ping_now_o(ping_now_o),
        .ping_mask_o(ping_mask_o), .sm_enable_o(sm_enable_o),
        .sm_inject_o(sm_inject_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic s);
        @(posedge clk_i);
        addr_i   <= a;
        wdata_i  <= d;
        secure_i <= s;
        wr_i     <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Data taken in the one cycle after the read edge
    task automatic rd(input logic [11:0] a, input logic s,
                      output logic [31:0] d);
        @(posedge clk_i);
        addr_i   <= a;
        secure_i <= s;
        rd_i     <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, 1'b1, d);
        chk_word(d, exp);
    endtask

    task automatic ev(input logic [3:0] v, input logic [3:0] c);
        @(posedge clk_i);
        err_valid_i     <= v;
        err_corrected_i <= c;
        @(posedge clk_i);
        err_valid_i <= 4'h0;
        #1;
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Bounded poll of the idle bit after a status write
    task automatic wait_idle();
        for (int i = 0; i < 20; i++) begin
            rd(`FM_UNIT_STATUS, 1'b1, rv);
            if (rv[0] === 1'b1) return;
        end
        n_fail++;
        $display("ERROR t=%0t got=%h exp=%h", $time, rv, 32'h1);
        complete_run();
    endtask

    initial begin
        {rstn_i, wr_i, rd_i, secure_i} = 4'h0;
        {addr_i, wdata_i, err_valid_i, err_corrected_i} = '0;
        n_fail = 0;
        check_count = 0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        #1;
        chk_bit(irq_o, 1'b0);
        chk_word(rdata_o, 32'h0);
        foreach (rst_rows[i]) rdchk(rst_rows[i].a, rst_rows[i].e);
        $display("test reset_values done");
        foreach (wr_rows[i]) begin
            wr(wr_rows[i].a, wr_rows[i].d, 1'b1);
            rdchk(wr_rows[i].a, wr_rows[i].e);
        end
        chk_word(key_o, 32'hA5A5_5A5A);
        chk_word(ping_ctl_o, 32'h1234_5678);
        chk_word(ping_now_o, 32'h0000_0001);
        chk_word(ping_mask_o[63:32], 32'hCAFE_F00D);
        chk_word(ping_mask_o[31:0], 32'hDEAD_BEEF);
        chk_word(sm_enable_o, 32'h0000_00FF);
        chk_word(sm_inject_o, 32'h0000_0003);
        $display("test write_readback done");
        wr(`FM_KEY, 32'h1111_1111, 1'b0);
        rd(`FM_KEY, 1'b0, rv);
        chk_word(rv, 32'h0);
        rdchk(`FM_KEY, 32'hA5A5_5A5A);
        $display("test non_secure done");
        wr(`FM_IRQ_MASK, 32'h0000_00FF, 1'b1);
        wr(12'h008, 32'h0000_000D, 1'b1);
        // Correctable with separation off counts as uncorrected
        ev(4'h1, 4'h1);
        chk_bit(fault_handling_irq_o, 1'b1);
        chk_bit(error_recovery_irq_o, 1'b1);
        chk_bit(irq_o, 1'b1);
        rdchk(12'h010, 32'h6030_0000);
        rdchk(`FM_GSR_LO, 32'h0000_0001);
        rdchk(`FM_IRQ_STATUS, 32'h0000_0011);
        ev(4'h1, 4'h0);
        rdchk(12'h010, 32'h6830_0000);
        wr(12'h010, 32'h6900_0000, 1'b1);
        rdchk(`FM_UNIT_STATUS, 32'h0);
        wait_idle();
        rdchk(12'h010, 32'h0030_0000);
        rdchk(`FM_GSR_LO, 32'h0);
        wr(`FM_IRQ_STATUS, 32'h0000_00FF, 1'b1);
        rdchk(`FM_IRQ_STATUS, 32'h0);
        chk_bit(irq_o, 1'b0);
        $display("test uncorrected_event done");
        ev(4'h2, 4'h2);
        chk_bit(fault_handling_irq_o, 1'b1);
        chk_bit(error_recovery_irq_o, 1'b0);
        rdchk(12'h050, 32'h4130_0000);
        rdchk(`FM_IRQ_STATUS, 32'h0000_0002);
        wr(`FM_IRQ_MASK, 32'h0, 1'b1);
        rdchk(`FM_IRQ_MASK, 32'h0);
        chk_bit(irq_o, 1'b0);
        rdchk(`FM_IRQ_STATUS, 32'h0000_0002);
        wr(`FM_IRQ_STATUS, 32'h0000_00FF, 1'b1);
        wr(`FM_IRQ_MASK, 32'h0000_00FF, 1'b1);
        rdchk(`FM_IRQ_STATUS, 32'h0);
        chk_bit(irq_o, 1'b0);
        // Uncorrected error with the classes kept apart
        ev(4'h2, 4'h0);
        chk_bit(error_recovery_irq_o, 1'b1);
        rdchk(12'h050, 32'h6930_0000);
        // Event and clear in one cycle: the event wins
        @(posedge clk_i);
        addr_i      <= 12'h050;
        wdata_i     <= 32'h6900_0000;
        wr_i        <= 1'b1;
        err_valid_i <= 4'h2;
        @(posedge clk_i);
        wr_i        <= 1'b0;
        err_valid_i <= 4'h0;
        rdchk(12'h050, 32'h6830_0000);
        wr(`FM_IRQ_STATUS, 32'h0000_00FF, 1'b1);
        $display("test corrected_and_mask done");
        wr(12'h008, 32'h0000_000C, 1'b1);
        wr(12'h088, 32'h0000_000C, 1'b1);
        ev(4'h5, 4'h0);
        chk_bit(irq_o, 1'b0);
        rdchk(12'h010, 32'h0030_0000);
        rdchk(12'h090, 32'h0030_0000);
        rdchk(`FM_IRQ_STATUS, 32'h0);
        $display("test logging_off done");
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdchk(12'h048, 32'h0000_0001);
        rdchk(`FM_KEY, 32'h0);
        chk_word(key_o, 32'h0);
        $display("test second_reset done");
        complete_run();
    end

endmodule
